// *** verilog/ivsr_consts.svh ***
// Register offsets, reset values and sizes of the vector and status registers
`ifndef IVSR_CONSTS_SVH
`define IVSR_CONSTS_SVH
`define IVSR_ADDR_W 12
`define IVSR_SVR_BASE 12'h080
`define IVSR_SVR_LAST 12'h0fc
`define IVSR_IVR_OFS 12'h100
`define IVSR_FVR_OFS 12'h104
`define IVSR_ISR_OFS 12'h108
`define IVSR_IPR_OFS 12'h10c
`define IVSR_IMR_OFS 12'h110
`define IVSR_SRC_NUM 32
`define IVSR_STACK_DEPTH 8
`define IVSR_WORD_RST 32'h0000_0000
`define IVSR_NUM_RST 5'h00
`define IVSR_PRIO_RST 3'h0
`define IVSR_SP_RST 4'h0
`define IVSR_SP_FULL 4'h8
`define IVSR_FAST_SRC 5'h00
`endif

// *** verilog/ivsr_pkg.sv ***
// Types shared by the vector and status register block
package ivsr_pkg;
  // One register bus access from software
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ivsr_bus_t;
  // One interrupt context: current source and its level
  typedef struct packed {
    logic valid;
    logic [4:0] num;
    logic [2:0] prio;
  } ivsr_ctx_t;
  // Acknowledge towards the source logic
  typedef struct packed {
    logic pulse;
    logic [4:0] num;
  } ivsr_ack_t;
endpackage

// *** verilog/ivsr_core.sv ***
// Handler address, vector and status registers of a vectored interrupt controller
// Software reads the vector register on entry to a service routine. In normal
// mode that read makes the best candidate current and stacks the old context.
// In protect mode the read only memorizes the candidate, and the following write
// does the stacking, so a debugger may read the vector freely.
// Each end of service pulse without a push in the same cycle pops one context back into current.
// The stack holds eight levels, one per priority level.
// The handler window and the vector, fast vector, status, pending and mask words are decoded here.
`timescale 1ns/1ps
`include "ivsr_consts.svh"

module ivsr_core (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Software register port
  input wire ivsr_pkg::ivsr_bus_t bus,
  output logic [31:0] rdData,
  // Source state from the source and mode logic
  input wire logic [31:0] pendingIn,
  input wire logic [31:0] maskIn,
  input wire logic [95:0] srcPriority,
  input wire logic protectMode,
  input wire logic endOfService,
  // Context towards the source logic
  output ivsr_pkg::ivsr_ack_t ack,
  output ivsr_pkg::ivsr_ctx_t current,
  output logic [31:0] pendingOut,
  output logic [31:0] maskOut
);
  import ivsr_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Handler words, one per source
  logic [31:0] handler_q [`IVSR_SRC_NUM];
  // Context stack and its pointer
  ivsr_ctx_t stack_q [`IVSR_STACK_DEPTH];
  logic [3:0] sp_q;
  // Current context and the memo of protect mode
  ivsr_ctx_t cur_q;
  ivsr_ctx_t memo_q;
  // Registered outputs
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  ivsr_ack_t ack_q;
  logic [31:0] pending_q;
  logic [31:0] mask_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Decoded accesses and context moves
  logic svrHit;
  logic [4:0] svrIdx;
  logic ivrRead;
  logic ivrWrite;
  logic pushNow;
  logic popNow;
  ivsr_ctx_t pushCtx;
  ivsr_ctx_t cand;
  // Stack level flags and helper words
  logic stackFull;
  logic stackEmpty;
  logic [31:0] eligible;
  logic [31:0] ivrWord;

  // Handler window spans one aligned word per source
  assign svrHit = (bus.addr >= `IVSR_SVR_BASE) && (bus.addr <= `IVSR_SVR_LAST)
                  && (bus.addr[1:0] == 2'b00);
  assign svrIdx = bus.addr[6:2];
  assign ivrRead = bus.rd && (bus.addr == `IVSR_IVR_OFS);
  assign ivrWrite = bus.wr && (bus.addr == `IVSR_IVR_OFS);

  // Stack level flags; a push on a full stack replaces current unsaved
  assign stackFull = (sp_q == `IVSR_SP_FULL);
  assign stackEmpty = (sp_q == `IVSR_SP_RST);

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Eligible sources: pending and enabled; the fast source is served elsewhere
  always_comb begin
    eligible = pendingIn & maskIn;
    eligible[`IVSR_FAST_SRC] = 1'b0;
  end

  // highest priority wins
  // Ties go to the lowest source number; the fast source never competes here
  // Live inputs are compared, so a read sees a source raised the cycle before
  always_comb begin
    logic [2:0] p;
    p = `IVSR_PRIO_RST;
    cand = '0;
    for (int i = 1; i < `IVSR_SRC_NUM; i++) begin
      p = srcPriority[i*3 +: 3];
      if (eligible[i] && (!cur_q.valid || p > cur_q.prio)
          && (!cand.valid || p > cand.prio)) begin
        cand.valid = 1'b1;
        cand.num = 5'(i);
        cand.prio = p;
      end
    end
  end

  // write stacks in protect mode
  // A write in normal mode, or a read in protect mode, changes no context
  always_comb begin
    pushNow = 1'b0;
    pushCtx = cand;
    if (!protectMode) begin
      pushNow = ivrRead && cand.valid;
    end else begin
      pushNow = ivrWrite && memo_q.valid;
      pushCtx = memo_q;
    end
  end

  // end of service pops
  // A pop in the cycle of a push is dropped; the push wins
  assign popNow = endOfService && !pushNow && (cur_q.valid || !stackEmpty);

  // ----------------------------------------------------------------
  // Handler registers
  // ----------------------------------------------------------------
  // handler address writes
  // Only aligned word offsets hit; byte offsets inside a word are ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `IVSR_SRC_NUM; i++) begin
        handler_q[i] <= `IVSR_WORD_RST;
      end
    end else if (bus.wr && svrHit) begin
      handler_q[svrIdx] <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Context and stack
  // ----------------------------------------------------------------
  // Current context: push takes the new source, pop restores the stacked one
  // A pop with an empty stack clears current, so a stray end of service is harmless
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_q <= '0;
      sp_q <= `IVSR_SP_RST;
      for (int i = 0; i < `IVSR_STACK_DEPTH; i++) begin
        stack_q[i] <= '0;
      end
    end else if (pushNow) begin
      cur_q <= pushCtx;
      if (!stackFull) begin
        stack_q[sp_q[2:0]] <= cur_q;
        sp_q <= sp_q + 4'h1;
      end
    end else if (popNow) begin
      if (!stackEmpty) begin
        cur_q <= stack_q[sp_q[2:0] - 3'h1];
        sp_q <= sp_q - 4'h1;
      end else begin
        cur_q <= '0;
      end
    end
  end

  // memorize on read
  // Protect mode keeps the candidate seen by the read until the write
  // An extra read before the write overwrites the memo with a fresh candidate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memo_q <= '0;
    end else if (protectMode && ivrRead) begin
      memo_q <= cand;
    end else if (pushNow || !protectMode) begin
      memo_q <= '0;
    end
  end

  // acknowledge pulse
  // Rises on the stacking edge itself, beside the new current context
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= '0;
    end else begin
      ack_q.pulse <= pushNow;
      ack_q.num <= pushNow ? pushCtx.num : `IVSR_NUM_RST;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // vector of chosen source
  // A fresh candidate goes first, since in normal mode the read itself makes it current
  always_comb begin
    ivrWord = handler_q[cur_q.num];
    if (cand.valid) begin
      ivrWord = handler_q[cand.num];
    end else if (!cur_q.valid) begin
      ivrWord = `IVSR_WORD_RST;
    end
  end

  // Read multiplexer; unmapped offsets and reserved bits read zero
  always_comb begin
    rdData_d = `IVSR_WORD_RST;
    if (svrHit) begin
      rdData_d = handler_q[svrIdx];
    end else begin
      case (bus.addr)
        // Normal vector word
        `IVSR_IVR_OFS: rdData_d = ivrWord;
        `IVSR_FVR_OFS: rdData_d = handler_q[`IVSR_FAST_SRC];
        `IVSR_ISR_OFS: rdData_d = {27'h0000000, cur_q.num};
        `IVSR_IPR_OFS: rdData_d = pending_q;
        `IVSR_IMR_OFS: rdData_d = mask_q;
        default: rdData_d = `IVSR_WORD_RST;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  // Zero outside the read slot, so a late sample never sees a stale word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= `IVSR_WORD_RST;
    end else begin
      rdData_q <= bus.rd ? rdData_d : `IVSR_WORD_RST;
    end
  end

  ivsr_word_reg i_pending_reg (
    .clk(clk),
    .arst_n(arst_n),
    .d(pendingIn),
    .q(pending_q)
  );

  ivsr_word_reg i_mask_reg (
    .clk(clk),
    .arst_n(arst_n),
    .d(maskIn),
    .q(mask_q)
  );

  // Outputs straight from flip-flops
  assign rdData = rdData_q;
  assign ack = ack_q;
  assign current = cur_q;
  assign pendingOut = pending_q;
  assign maskOut = mask_q;
endmodule

// ----------------------------------------------------------------
// Word register
// ----------------------------------------------------------------
// One 32-bit register cleared by reset, loaded on every edge
// Shared by the pending and mask copies so both reset alike
module ivsr_word_reg (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Word in and out
  input wire logic [31:0] d,
  output logic [31:0] q
);
  import ivsr_pkg::*;

  // Copy of the word, one cycle late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= `IVSR_WORD_RST;
    end else begin
      q <= d;
    end
  end
endmodule

// *** tb/ivsr_core_asserts.sv ***
// Port assertions of the vector and status register block
`timescale 1ns/1ps
`include "ivsr_consts.svh"
module ivsr_core_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Watched ports
  input wire ivsr_pkg::ivsr_bus_t bus,
  input wire logic [31:0] rdData,
  input wire logic [31:0] pendingIn,
  input wire logic [31:0] maskIn,
  input wire logic protectMode,
  input wire ivsr_pkg::ivsr_ack_t ack,
  input wire ivsr_pkg::ivsr_ctx_t current,
  input wire logic [31:0] pendingOut,
  input wire logic [31:0] maskOut
);
  import ivsr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic ivrRd;
  logic ivrWr;
  // Vector register accesses
  assign ivrRd = bus.rd && bus.addr == `IVSR_IVR_OFS;
  assign ivrWr = bus.wr && bus.addr == `IVSR_IVR_OFS;
  a_rd_data_quiet: assert property (!$past(bus.rd) |-> rdData == 32'h0)
    else $error("read data outside read slot");
  a_ack_cause: assert property (ack.pulse |->
    $past(ivrRd && !protectMode || ivrWr && protectMode))
    else $error("acknowledge without vector access");
  a_prot_rd_quiet: assert property (ivrRd && protectMode |=> !ack.pulse)
    else $error("protect read acknowledged");
  a_norm_wr_quiet: assert property (ivrWr && !protectMode |=> !ack.pulse)
    else $error("normal vector write acknowledged");
  a_ack_ctx: assert property (ack.pulse |->
    current.valid && current.num == ack.num && ack.num != 5'h00)
    else $error("acknowledge differs from current");
  a_pend_copy: assert property ($past(arst_n) |-> pendingOut == $past(pendingIn))
    else $error("pending copy wrong");
  a_mask_copy: assert property ($past(arst_n) |-> maskOut == $past(maskIn))
    else $error("mask copy wrong");
  a_status_num: assert property ($past(bus.rd) && $past(bus.addr) == `IVSR_ISR_OFS |->
    rdData == {27'h0, $past(current.num)})
    else $error("status number wrong");
  a_vec_empty: assert property ($past(ivrRd && !protectMode && !current.valid) &&
    !ack.pulse |-> rdData == 32'h0)
    else $error("empty vector not zero");
endmodule
bind ivsr_core ivsr_core_asserts i_ivsr_core_asserts (.clk(clk), .arst_n(arst_n), .bus(bus),
  .rdData(rdData), .pendingIn(pendingIn), .maskIn(maskIn), .protectMode(protectMode),
  .ack(ack), .current(current), .pendingOut(pendingOut), .maskOut(maskOut));

// *** tb/ivsr_src_model.sv ***
// Behavioural model of the interrupt sources and the service routine
`timescale 1ns/1ps
module ivsr_src_model (
  // Clock and acknowledge
  input wire logic clk,
  input wire ivsr_pkg::ivsr_ack_t ack,
  // Source state towards the block
  output logic [31:0] pendingIn,
  output logic [31:0] maskIn,
  output logic [95:0] srcPriority,
  output logic protectMode,
  output logic endOfService
);
  import ivsr_pkg::*;
  // Quiet sources at time zero
  initial begin
    pendingIn = 32'h0;
    maskIn = 32'h0;
    srcPriority = 96'h0;
    protectMode = 1'b0;
    endOfService = 1'b0;
  end
  // Level source drops its request once acknowledged
  always @(posedge clk) begin
    if (ack.pulse) begin
      pendingIn[ack.num] <= 1'b0;
    end
  end
  // Sets the pending and mask lines and the mode
  task automatic set(input logic [31:0] p, input logic [31:0] m, input logic pm);
    @(posedge clk);
    pendingIn <= p;
    maskIn <= m;
    protectMode <= pm;
  endtask
  // Raises one enabled source at a priority
  task automatic raise(input int n, input logic [2:0] pr);
    @(posedge clk);
    pendingIn[n] <= 1'b1;
    maskIn[n] <= 1'b1;
    srcPriority[3*n+:3] <= pr;
  endtask
  task automatic done();
    @(posedge clk);
    endOfService <= 1'b1;
    @(posedge clk);
    endOfService <= 1'b0;
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking testbench of the vector and status register block
`timescale 1ns/1ps
module tb;
  import ivsr_pkg::*;
  logic clk;
  logic arst_n;
  ivsr_bus_t bus;
  logic [31:0] rdData, pendingIn, maskIn, pendingOut, maskOut;
  logic [95:0] srcPriority;
  logic protectMode, endOfService;
  ivsr_ack_t ack;
  ivsr_ctx_t current;
  int err_count, samples_checked;
  ivsr_core i_ivsr_core (.clk(clk), .arst_n(arst_n), .bus(bus), .rdData(rdData),
    .pendingIn(pendingIn), .maskIn(maskIn), .srcPriority(srcPriority),
    .protectMode(protectMode), .endOfService(endOfService), .ack(ack), .current(current),
    .pendingOut(pendingOut), .maskOut(maskOut));
  ivsr_src_model i_ivsr_src_model (.clk(clk), .ack(ack), .pendingIn(pendingIn),
    .maskIn(maskIn), .srcPriority(srcPriority), .protectMode(protectMode),
    .endOfService(endOfService));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] hv(input int n);
    return 32'h0000_4000 + 32'(n) * 32'h10;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdck(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdData, exp);
  endtask
  task automatic s_regs();
    rdck(12'h100, 32'h0);
    rdck(12'h108, 32'h0);
    rdck(12'h110, 32'h0);
    for (int n = 0; n < 32; n++) begin
      rdck(12'h080 + 12'(4 * n), 32'h0);
      wr(12'h080 + 12'(4 * n), hv(n));
    end
    for (int n = 0; n < 32; n++) rdck(12'h080 + 12'(4 * n), hv(n));
    wr(12'h104, 32'h0);
    rdck(12'h104, hv(0));
    rdck(12'h200, 32'h0);
  endtask
  task automatic s_lines();
    i_ivsr_src_model.set(32'h0007_01ff, 32'h0005_00aa, 1'b0);
    rdck(12'h10c, 32'h0007_01ff);
    rdck(12'h110, 32'h0005_00aa);
    i_ivsr_src_model.set(32'h0, 32'h0, 1'b0);
  endtask
  task automatic s_normal();
    i_ivsr_src_model.raise(5, 3'h3);
    i_ivsr_src_model.raise(9, 3'h6);
    rdck(12'h100, hv(9));
    rdck(12'h108, 32'h9);
    wr(12'h100, 32'h0);
    rdck(12'h108, 32'h9);
    rdck(12'h100, hv(9));
    i_ivsr_src_model.done();
    rdck(12'h108, 32'h0);
    rdck(12'h100, hv(5));
    i_ivsr_src_model.raise(9, 3'h6);
    rdck(12'h100, hv(9));
    rdck(12'h108, 32'h9);
    i_ivsr_src_model.done();
    rdck(12'h108, 32'h5);
    i_ivsr_src_model.done();
    rdck(12'h100, 32'h0);
  endtask
  task automatic s_protect();
    i_ivsr_src_model.set(32'h0, 32'h0, 1'b1);
    i_ivsr_src_model.raise(5, 3'h3);
    rdck(12'h100, hv(5));
    rdck(12'h108, 32'h0);
    wr(12'h100, 32'h0);
    rdck(12'h108, 32'h5);
    i_ivsr_src_model.done();
    i_ivsr_src_model.set(32'h0, 32'h0, 1'b0);
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    bus = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    s_regs();
    s_lines();
    s_normal();
    s_protect();
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
